// ---- include/scsi_pci_pkg.sv ----
// shared constants and carriers for the scsi host pci command unit
package scsi_pci_pkg;
  // ==========================================================
  // pci command codes (active-high form of c/be)
  localparam logic [3:0] CMD_INT_ACK = 4'h0;
  localparam logic [3:0] CMD_SPECIAL = 4'h1;
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;
  localparam logic [3:0] CMD_MEM_RD_MULT = 4'hC;
  localparam logic [3:0] CMD_DUAL_ADDR = 4'hD;
  localparam logic [3:0] CMD_MEM_RD_LINE = 4'hE;
  localparam logic [3:0] CMD_MEM_WR_INV = 4'hF;
  // ==========================================================
  // buffer sizing
  localparam int FIFO_BYTES = 256;
  localparam int FIFO_WORD_BYTES = 8;
  localparam int FIFO_DEPTH = FIFO_BYTES / FIFO_WORD_BYTES;
  localparam int FIFO_WIDTH = 72;
  // ==========================================================
  // scsi side
  localparam logic [4:0] MAX_OFFSET = 5'h0F;
  localparam logic [2:0] LAST_NARROW = 3'h7;
  localparam logic [2:0] LAST_WIDE = 3'h6;
  // ==========================================================
  // types
  typedef enum logic [2:0] {
    TGT_NONE, TGT_IO_RD, TGT_IO_WR, TGT_MEM_RD, TGT_MEM_WR, TGT_CFG_RD, TGT_CFG_WR
  } tgt_op_e;
  typedef struct packed {
    logic [63:0] data;
    logic [7:0] par;
  } fifo_word_s;
  typedef struct packed {
    logic valid;
    logic [31:0] data;
    logic par;
  } pci_beat_s;
  typedef struct packed {
    logic start;
    logic write;
    logic [31:0] addrHi;
    logic [7:0] words;
  } mst_req_s;
endpackage

// ---- src/scsi_host_pci_command_unit.sv ----
// pci command decode, master command choice, parity datapath and scsi side
`timescale 1ns/100ps
module scsi_host_pci_command_unit #(
  parameter int DEPTH = scsi_pci_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tgtStart,
  input wire logic [3:0] tgtCmd,
  input wire logic [31:0] tgtAd,
  input wire logic tgtPar,
  input wire logic [7:0] cacheLineSize,
  input wire logic readLineSel,
  input wire logic mwiEnable,
  input wire scsi_pci_pkg::mst_req_s mstReq,
  input wire scsi_pci_pkg::pci_beat_s pciBeat,
  output logic pciReady,
  input wire logic scsiWide,
  input wire logic [15:0] scsiDataIn,
  input wire logic scsiReq,
  input wire logic [3:0] myId,
  input wire logic arbStart,
  input wire logic diffMode,
  input wire logic powerDown,
  output logic devselQ,
  output scsi_pci_pkg::tgt_op_e tgtOpQ,
  output logic [3:0] mstCmdQ,
  output logic mstCmdValidQ,
  output logic [7:0] mstWordsQ,
  output logic [7:0] mstMinWordsQ,
  output logic perrQ,
  output logic serrQ,
  output logic [15:0] scsiDataQ,
  output logic [1:0] scsiParQ,
  output logic scsiDataOeN,
  output logic scsiAckQ,
  output logic offsetErrQ,
  output logic arbWonQ,
  output logic arbDoneQ,
  output logic activityQ,
  output logic termPowerDownQ,
  output logic diffEnableQ,
  output logic diffDirQ
);
  typedef enum logic {MST_IDLE, MST_DUAL} mst_state_e;
  typedef enum logic {ARB_IDLE, ARB_BID} arb_state_e;
  typedef struct packed {
    mst_state_e mst;
    logic [3:0] pendCmd;
    logic [3:0] mstCmd;
    logic mstCmdValid;
    logic [7:0] mstWords;
    logic [7:0] mstMin;
    logic devsel;
    scsi_pci_pkg::tgt_op_e tgtOp;
    logic perr;
    logic serr;
    logic [31:0] lowWord;
    logic [3:0] lowPar;
    logic haveLow;
    logic [2:0] byteIdx;
    logic [15:0] scsiData;
    logic [1:0] scsiPar;
    logic scsiOeN;
    logic ack;
    logic [4:0] offset;
    logic offsetErr;
    arb_state_e arb;
    logic arbWon;
    logic arbDone;
    logic activity;
    logic termPd;
    logic diffEn;
    logic diffDir;
  } state_s;
  state_s s_q;
  state_s s_d;
  // ==========================================================
  // helpers
  function automatic logic oddPar(input logic [7:0] b);
    return ~^b;
  endfunction
  function automatic scsi_pci_pkg::tgt_op_e tgtDecode(input logic [3:0] c);
    unique case (c)
      scsi_pci_pkg::CMD_IO_RD: return scsi_pci_pkg::TGT_IO_RD;
      scsi_pci_pkg::CMD_IO_WR: return scsi_pci_pkg::TGT_IO_WR;
      scsi_pci_pkg::CMD_MEM_RD: return scsi_pci_pkg::TGT_MEM_RD;
      scsi_pci_pkg::CMD_MEM_WR: return scsi_pci_pkg::TGT_MEM_WR;
      scsi_pci_pkg::CMD_CFG_RD: return scsi_pci_pkg::TGT_CFG_RD;
      scsi_pci_pkg::CMD_CFG_WR: return scsi_pci_pkg::TGT_CFG_WR;
      scsi_pci_pkg::CMD_MEM_RD_MULT: return scsi_pci_pkg::TGT_MEM_RD;
      scsi_pci_pkg::CMD_MEM_RD_LINE: return scsi_pci_pkg::TGT_MEM_RD;
      scsi_pci_pkg::CMD_MEM_WR_INV: return scsi_pci_pkg::TGT_MEM_WR;
      default: return scsi_pci_pkg::TGT_NONE;
    endcase
  endfunction
  function automatic logic [3:0] mstSelect(input logic wr, input logic [7:0] words,
                                            input logic [7:0] cls, input logic mwi, input logic rls);
    logic ext;
    ext = (cls != 8'h00) && (words >= cls);
    if (wr) begin
      return (ext && mwi) ? scsi_pci_pkg::CMD_MEM_WR_INV : scsi_pci_pkg::CMD_MEM_WR;
    end
    if (!ext) begin
      return scsi_pci_pkg::CMD_MEM_RD;
    end
    return rls ? scsi_pci_pkg::CMD_MEM_RD_LINE : scsi_pci_pkg::CMD_MEM_RD_MULT;
  endfunction
  function automatic logic [3:0] arbWinner(input logic [15:0] bus);
    logic [3:0] w;
    logic found;
    w = 4'h0;
    found = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (!found && bus[i]) begin
        w = 4'(i);
        found = 1'b1;
      end
    end
    for (int i = 15; i >= 8; i--) begin
      if (!found && bus[i]) begin
        w = 4'(i);
        found = 1'b1;
      end
    end
    return w;
  endfunction
  // ==========================================================
  // input gating while powered down
  logic live;
  logic tStart;
  logic bValid;
  logic mStart;
  logic sReq;
  logic aStart;
  logic [15:0] sBus;
  assign live = !powerDown;
  assign tStart = tgtStart && live;
  assign bValid = pciBeat.valid && live;
  assign mStart = mstReq.start && live;
  assign sReq = scsiReq && live;
  assign aStart = arbStart && live;
  assign sBus = live ? scsiDataIn : 16'h0000;
  // ==========================================================
  // burst buffer
  scsi_pci_pkg::fifo_word_s fifoIn;
  scsi_pci_pkg::fifo_word_s fifoOut;
  logic fifoInValid;
  logic fifoOutValid;
  logic fifoPop;
  logic beatTaken;
  logic beatBad;
  logic [3:0] beatPar;
  logic outBad;
  logic [7:0] byteLo;
  logic [7:0] byteHi;
  logic sendNow;
  logic lastByte;
  assign beatTaken = bValid && pciReady;
  assign beatBad = (^pciBeat.data) ^ pciBeat.par;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      beatPar[i] = oddPar(pciBeat.data[8*i +: 8]);
    end
  end
  assign fifoIn.data = {pciBeat.data, s_q.lowWord};
  assign fifoIn.par = {beatPar, s_q.lowPar};
  assign fifoInValid = beatTaken && s_q.haveLow;
  sync_fifo #(
    .WIDTH(scsi_pci_pkg::FIFO_WIDTH),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .inData(fifoIn),
    .inValid(fifoInValid),
    .inReady(pciReady),
    .outData(fifoOut),
    .outValid(fifoOutValid),
    .outReady(fifoPop)
  );
  assign byteLo = fifoOut.data[{s_q.byteIdx, 3'b000} +: 8];
  assign byteHi = fifoOut.data[{s_q.byteIdx + 3'h1, 3'b000} +: 8];
  assign outBad = sendNow && ((oddPar(byteLo) != fifoOut.par[s_q.byteIdx]) ||
                  (scsiWide && (oddPar(byteHi) != fifoOut.par[s_q.byteIdx + 3'h1])));
  assign sendNow = (s_q.offset != 5'h00) && fifoOutValid && live && (s_q.arb == ARB_IDLE);
  assign lastByte = scsiWide ? (s_q.byteIdx == scsi_pci_pkg::LAST_WIDE) :
                    (s_q.byteIdx == scsi_pci_pkg::LAST_NARROW);
  assign fifoPop = sendNow && lastByte;
  // ==========================================================
  // next state
  logic [3:0] selCmd;
  logic [4:0] offNext;
  assign selCmd = mstSelect(mstReq.write, mstReq.words, cacheLineSize, mwiEnable, readLineSel);
  assign offNext = s_q.offset + 5'(sReq) - 5'(sendNow);
  always_comb begin
    s_d = s_q;
    s_d.devsel = 1'b0;
    s_d.tgtOp = scsi_pci_pkg::TGT_NONE;
    s_d.mstCmdValid = 1'b0;
    s_d.perr = 1'b0;
    s_d.serr = 1'b0;
    s_d.ack = 1'b0;
    s_d.arbDone = 1'b0;
    s_d.scsiOeN = 1'b1;
    // target decode
    if (tStart) begin
      s_d.tgtOp = tgtDecode(tgtCmd);
      s_d.devsel = (tgtDecode(tgtCmd) != scsi_pci_pkg::TGT_NONE);
      s_d.serr = (^tgtAd) ^ tgtPar;
    end
    // master command
    unique case (s_q.mst)
      MST_IDLE: begin
        if (mStart) begin
          s_d.mstCmdValid = 1'b1;
          s_d.mstWords = mstReq.words;
          s_d.mstMin = (selCmd == scsi_pci_pkg::CMD_MEM_RD ||
                        selCmd == scsi_pci_pkg::CMD_MEM_WR) ? 8'h01 : cacheLineSize;
          if (mstReq.addrHi != 32'h0000_0000) begin
            s_d.mstCmd = scsi_pci_pkg::CMD_DUAL_ADDR;
            s_d.pendCmd = selCmd;
            s_d.mst = MST_DUAL;
          end else begin
            s_d.mstCmd = selCmd;
          end
        end
      end
      MST_DUAL: begin
        s_d.mstCmdValid = 1'b1;
        s_d.mstCmd = s_q.pendCmd;
        s_d.mst = MST_IDLE;
      end
    endcase
    // pairing of pci beats into buffer words
    if (beatTaken) begin
      s_d.perr = beatBad;
      if (!s_q.haveLow) begin
        s_d.lowWord = pciBeat.data;
        s_d.lowPar = beatPar;
      end
      s_d.haveLow = !s_q.haveLow;
    end
    if (outBad) begin
      s_d.perr = 1'b1;
    end
    // synchronous offset
    s_d.offset = offNext;
    if (sReq && (s_q.offset == scsi_pci_pkg::MAX_OFFSET) && !sendNow) begin
      s_d.offset = s_q.offset;
      s_d.offsetErr = 1'b1;
    end
    // data out on ack
    if (sendNow) begin
      s_d.ack = 1'b1;
      s_d.scsiOeN = 1'b0;
      s_d.scsiData = {scsiWide ? byteHi : 8'h00, byteLo};
      s_d.scsiPar = {oddPar(scsiWide ? byteHi : 8'h00), oddPar(byteLo)};
      s_d.byteIdx = lastByte ? 3'h0 : s_q.byteIdx + (scsiWide ? 3'h2 : 3'h1);
    end
    // arbitration
    unique case (s_q.arb)
      ARB_IDLE: begin
        if (aStart && !sendNow) begin
          s_d.arb = ARB_BID;
          s_d.scsiOeN = 1'b0;
          s_d.scsiData = 16'h0001 << myId;
          s_d.scsiPar = {oddPar(s_d.scsiData[15:8]), oddPar(s_d.scsiData[7:0])};
        end
      end
      ARB_BID: begin
        s_d.arb = ARB_IDLE;
        s_d.arbDone = 1'b1;
        s_d.arbWon = (arbWinner(sBus | s_q.scsiData) == myId);
      end
    endcase
    // side-band controls
    s_d.activity = sendNow || fifoOutValid || s_q.haveLow;
    s_d.termPd = powerDown;
    s_d.diffEn = diffMode && live;
    s_d.diffDir = !s_d.scsiOeN;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.scsiOeN <= 1'b1;
      s_q.scsiPar <= 2'h3;
    end else begin
      s_q <= s_d;
    end
  end
  // ==========================================================
  // outputs
  assign devselQ = s_q.devsel;
  assign tgtOpQ = s_q.tgtOp;
  assign mstCmdQ = s_q.mstCmd;
  assign mstCmdValidQ = s_q.mstCmdValid;
  assign mstWordsQ = s_q.mstWords;
  assign mstMinWordsQ = s_q.mstMin;
  assign perrQ = s_q.perr;
  assign serrQ = s_q.serr;
  assign scsiDataQ = s_q.scsiData;
  assign scsiParQ = s_q.scsiPar;
  assign scsiDataOeN = s_q.scsiOeN;
  assign scsiAckQ = s_q.ack;
  assign offsetErrQ = s_q.offsetErr;
  assign arbWonQ = s_q.arbWon;
  assign arbDoneQ = s_q.arbDone;
  assign activityQ = s_q.activity;
  assign termPowerDownQ = s_q.termPd;
  assign diffEnableQ = s_q.diffEn;
  assign diffDirQ = s_q.diffDir;
  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence dualStart;
    mStart && s_q.mst == MST_IDLE && mstReq.addrHi != 32'h0000_0000;
  endsequence
  sequence dualIssue;
    mstCmdValidQ && mstCmdQ == scsi_pci_pkg::CMD_DUAL_ADDR ##1
    mstCmdValidQ && mstCmdQ != scsi_pci_pkg::CMD_DUAL_ADDR;
  endsequence
  a_unsupported_nodevsel: assert property (tStart && tgtDecode(tgtCmd) == scsi_pci_pkg::TGT_NONE
    |=> !devselQ) else $error("unsupported command claimed");
  a_target_claims: assert property (tStart && (tgtCmd == scsi_pci_pkg::CMD_IO_WR ||
    tgtCmd == scsi_pci_pkg::CMD_CFG_WR) |=> devselQ) else $error("legal command unclaimed");
  a_mult_as_read: assert property (tStart && (tgtCmd == scsi_pci_pkg::CMD_MEM_RD_MULT ||
    tgtCmd == scsi_pci_pkg::CMD_MEM_RD_LINE) |=> tgtOpQ == scsi_pci_pkg::TGT_MEM_RD)
    else $error("extended read not served as read");
  a_inv_as_write: assert property (tStart && tgtCmd == scsi_pci_pkg::CMD_MEM_WR_INV
    |=> tgtOpQ == scsi_pci_pkg::TGT_MEM_WR) else $error("mwi not served as write");
  a_master_mem_only: assert property (mstCmdValidQ |-> mstCmdQ[2] && mstCmdQ[3:1] != 3'b010)
    else $error("master issued non-memory command");
  a_dual_then_cmd: assert property (dualStart |=> dualIssue)
    else $error("dual address sequence broken");
  a_ext_sized: assert property (mStart && s_q.mst == MST_IDLE && mstReq.addrHi == 32'h0000_0000
    && cacheLineSize != 8'h00 && mstReq.words >= cacheLineSize && (!mstReq.write || mwiEnable)
    |=> mstMinWordsQ == $past(cacheLineSize)) else $error("extended command size wrong");
  a_line_select: assert property (mStart && s_q.mst == MST_IDLE && !mstReq.write
    && mstReq.addrHi == 32'h0000_0000 && cacheLineSize != 8'h00 && mstReq.words >= cacheLineSize
    |=> mstCmdQ == ($past(readLineSel) ? scsi_pci_pkg::CMD_MEM_RD_LINE :
    scsi_pci_pkg::CMD_MEM_RD_MULT)) else $error("read line select ignored");
  a_parity_report: assert property (beatTaken && beatBad |=> perrQ)
    else $error("bad pci parity not reported");
  a_scsi_odd_par: assert property (!scsiDataOeN |-> oddPar(scsiDataQ[7:0]) == scsiParQ[0]
    && oddPar(scsiDataQ[15:8]) == scsiParQ[1]) else $error("scsi parity not odd");
  a_low_byte_wins: assert property (s_q.arb == ARB_BID && sBus[7:0] != 8'h00 && myId[3]
    |=> arbDoneQ && !arbWonQ) else $error("high byte id beat low byte");
  a_offset_bound: assert property (s_q.offset <= scsi_pci_pkg::MAX_OFFSET)
    else $error("request offset above limit");
  a_power_gate: assert property (powerDown && s_q.mst == MST_IDLE |=> !devselQ && !scsiAckQ
    && !mstCmdValidQ
    && termPowerDownQ) else $error("input acted during power-down");
endmodule

// ---- src/sync_fifo.sv ----
// synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module sync_fifo #(
  parameter int WIDTH = 72,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
    logic ready;
  } fifo_state_s;
  fifo_state_s s_q;
  fifo_state_s s_d;
  logic push;
  logic pop;
  // ==========================================================
  // handshakes
  assign push = inValid && s_q.ready;
  assign outValid = (s_q.count != '0);
  assign pop = outValid && outReady;
  assign outData = s_q.mem[s_q.rd];
  assign inReady = s_q.ready;
  // ==========================================================
  // next state; depth must be a power of two
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = inData;
      s_d.wr = s_q.wr + AW'(1);
    end
    if (pop) begin
      s_d.rd = s_q.rd + AW'(1);
    end
    s_d.count = s_q.count + (AW+1)'(push) - (AW+1)'(pop);
    s_d.ready = (s_d.count < (AW+1)'(DEPTH));
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ---- tb/pci_host_model.sv ----
// host bridge model that feeds data dwords into the unit
`timescale 1ns/100ps
module pci_host_model (
  input wire logic clk,
  input wire logic pciReady,
  output scsi_pci_pkg::pci_beat_s beat
);
  initial begin
    beat = '0;
  end

  // ==========================================================
  // one dword, held until taken, then the line shows its inverse
  task automatic send(input logic [31:0] d, input logic badPar, input int gap);
    logic r;
    repeat (gap + 1) @(posedge clk);
    beat.valid <= 1'h1;
    beat.data <= d;
    beat.par <= (^d) ^ badPar;
    r = 1'h0;
    while (!r) begin
      @(negedge clk);
      r = pciReady;
      @(posedge clk);
    end
    beat.valid <= 1'h0;
    beat.data <= ~d;
    beat.par <= ~beat.par;
  endtask
endmodule

// ---- tb/scsi_host_pci_command_unit_tb.sv ----
// self-checking testbench for the scsi host pci command unit
`timescale 1ns/100ps
module scsi_host_pci_command_unit_tb;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic tgtStart = 1'h0;
  logic [3:0] tgtCmd = 4'h0;
  logic [31:0] tgtAd = 32'h0000_0000;
  logic tgtPar = 1'h0;
  logic [7:0] cacheLineSize = 8'h00;
  logic readLineSel = 1'h0;
  logic mwiEnable = 1'h0;
  scsi_pci_pkg::mst_req_s mstReq = '0;
  scsi_pci_pkg::pci_beat_s pciBeat;
  logic pciReady;
  logic scsiWide = 1'h0;
  logic [15:0] scsiDataIn = 16'h0000;
  logic scsiReq = 1'h0;
  logic [3:0] myId = 4'h0;
  logic arbStart = 1'h0;
  logic diffMode = 1'h0;
  logic powerDown = 1'h0;
  logic devselQ, mstCmdValidQ, perrQ, serrQ, scsiDataOeN, scsiAckQ, offsetErrQ;
  logic arbWonQ, arbDoneQ, activityQ, termPowerDownQ, diffEnableQ, diffDirQ;
  scsi_pci_pkg::tgt_op_e tgtOpQ;
  logic [3:0] mstCmdQ;
  logic [7:0] mstWordsQ, mstMinWordsQ;
  logic [15:0] scsiDataQ;
  logic [1:0] scsiParQ;
  int error_cnt = 0;
  int n_compared = 0;
  int perrCnt = 0;
  int serrCnt = 0;
  logic [17:0] ackQ[$];

  always #2 clk = ~clk;

  pci_host_model u_pci_host_model (.clk(clk), .pciReady(pciReady), .beat(pciBeat));

  scsi_host_pci_command_unit u_scsi_host_pci_command_unit (
    .clk(clk), .reset_n(reset_n), .tgtStart(tgtStart), .tgtCmd(tgtCmd), .tgtAd(tgtAd),
    .tgtPar(tgtPar), .cacheLineSize(cacheLineSize), .readLineSel(readLineSel),
    .mwiEnable(mwiEnable), .mstReq(mstReq), .pciBeat(pciBeat), .pciReady(pciReady),
    .scsiWide(scsiWide), .scsiDataIn(scsiDataIn), .scsiReq(scsiReq), .myId(myId),
    .arbStart(arbStart), .diffMode(diffMode), .powerDown(powerDown), .devselQ(devselQ),
    .tgtOpQ(tgtOpQ), .mstCmdQ(mstCmdQ), .mstCmdValidQ(mstCmdValidQ), .mstWordsQ(mstWordsQ),
    .mstMinWordsQ(mstMinWordsQ), .perrQ(perrQ), .serrQ(serrQ), .scsiDataQ(scsiDataQ),
    .scsiParQ(scsiParQ), .scsiDataOeN(scsiDataOeN), .scsiAckQ(scsiAckQ),
    .offsetErrQ(offsetErrQ), .arbWonQ(arbWonQ), .arbDoneQ(arbDoneQ), .activityQ(activityQ),
    .termPowerDownQ(termPowerDownQ), .diffEnableQ(diffEnableQ), .diffDirQ(diffDirQ)
  );

  // ==========================================================
  // shared helpers
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask

  always @(negedge clk) begin
    if (perrQ === 1'h1) perrCnt++;
    if (serrQ === 1'h1) serrCnt++;
    if (scsiAckQ === 1'h1) begin
      ackQ.push_back({scsiParQ, scsiDataQ});
      check("oe with ack", 32'h0000_0000, {31'h0, scsiDataOeN});
      check("diff dir with ack", 32'h0000_0001, {31'h0, diffDirQ});
    end
  end

  task automatic do_reset();
    @(posedge clk);
    reset_n <= 1'h0;
    repeat (4) @(posedge clk);
    reset_n <= 1'h1;
  endtask

  task automatic tgt_access(input logic [3:0] cmd, input logic par);
    @(posedge clk);
    tgtStart <= 1'h1;
    tgtCmd <= cmd;
    tgtAd <= 32'h0000_1000;
    tgtPar <= par;
    @(posedge clk);
    tgtStart <= 1'h0;
    #1;
  endtask

  task automatic mst_issue(input logic wr, input logic [31:0] hi, input logic [7:0] words,
      input logic [7:0] cls, input logic sel, input logic mwi, input logic [3:0] expCmd,
      input logic [7:0] expMin);
    @(posedge clk);
    mstReq <= '{start: 1'h1, write: wr, addrHi: hi, words: words};
    cacheLineSize <= cls;
    readLineSel <= sel;
    mwiEnable <= mwi;
    @(posedge clk);
    mstReq.start <= 1'h0;
    #1;
    if (hi != 32'h0000_0000) begin
      check("dac cmd", {28'h0, scsi_pci_pkg::CMD_DUAL_ADDR}, {28'h0, mstCmdQ});
      @(posedge clk);
      #1;
    end
    check("cmd valid", 32'h0000_0001, {31'h0, mstCmdValidQ});
    check("cmd code", {28'h0, expCmd}, {28'h0, mstCmdQ});
    check("burst words", {24'h0, words}, {24'h0, mstWordsQ});
    check("min words", {24'h0, expMin}, {24'h0, mstMinWordsQ});
  endtask

  task automatic scsi_take(input logic [15:0] exp, input logic wide);
    int w;
    logic [17:0] got;
    @(posedge clk);
    scsiReq <= 1'h1;
    @(posedge clk);
    scsiReq <= 1'h0;
    w = 0;
    while (ackQ.size() == 0 && w < 10) begin
      @(posedge clk);
      w++;
    end
    if (ackQ.size() == 0) begin
      check("ack seen", 32'h0000_0001, 32'h0000_0000);
    end else begin
      got = ackQ.pop_front();
      check("scsi data", {16'h0, exp}, {16'h0, wide ? got[15:0] : {8'h00, got[7:0]}});
      check("scsi par lo", {31'h0, ~^exp[7:0]}, {31'h0, got[16]});
      if (wide) check("scsi par hi", {31'h0, ~^exp[15:8]}, {31'h0, got[17]});
    end
  endtask

  task automatic arb_run(input logic [3:0] id, input logic [15:0] others, input logic won);
    int w;
    @(posedge clk);
    myId <= id;
    scsiDataIn <= others | (16'h0001 << id);
    arbStart <= 1'h1;
    @(posedge clk);
    arbStart <= 1'h0;
    #1;
    w = 0;
    while (arbDoneQ !== 1'h1 && w < 6) begin
      @(posedge clk);
      #1;
      w++;
    end
    check("arb done", 32'h0000_0001, {31'h0, arbDoneQ});
    check("arb won", {31'h0, won}, {31'h0, arbWonQ});
  endtask

  // ==========================================================
  // scenarios
  task automatic test_target();
    scsi_pci_pkg::tgt_op_e e;
    for (int c = 0; c < 16; c++) begin
      case (c)
        2: e = scsi_pci_pkg::TGT_IO_RD;
        3: e = scsi_pci_pkg::TGT_IO_WR;
        6, 12, 14: e = scsi_pci_pkg::TGT_MEM_RD;
        7, 15: e = scsi_pci_pkg::TGT_MEM_WR;
        10: e = scsi_pci_pkg::TGT_CFG_RD;
        11: e = scsi_pci_pkg::TGT_CFG_WR;
        default: e = scsi_pci_pkg::TGT_NONE;
      endcase
      tgt_access(4'(c), 1'h1);
      check("devsel", {31'h0, e != scsi_pci_pkg::TGT_NONE}, {31'h0, devselQ});
      check("target op", {29'h0, e}, {29'h0, tgtOpQ});
    end
    @(posedge clk);
    powerDown <= 1'h1;
    diffMode <= 1'h1;
    tgt_access(scsi_pci_pkg::CMD_MEM_RD, 1'h1);
    check("devsel in power down", 32'h0000_0000, {31'h0, devselQ});
    check("terminator power down", 32'h0000_0001, {31'h0, termPowerDownQ});
    check("diff enable in power down", 32'h0000_0000, {31'h0, diffEnableQ});
    @(posedge clk);
    powerDown <= 1'h0;
    tgt_access(scsi_pci_pkg::CMD_MEM_RD, 1'h0);
    check("terminator powered", 32'h0000_0000, {31'h0, termPowerDownQ});
    check("diff enable", 32'h0000_0001, {31'h0, diffEnableQ});
    repeat (2) @(posedge clk);
    check("address parity errors", 32'h0000_0001, serrCnt);
  endtask

  task automatic test_master();
    mst_issue(1'h0, 32'h0000_0000, 8'h10, 8'h08, 1'h1, 1'h0, 4'hE, 8'h08);
    mst_issue(1'h0, 32'h0000_0000, 8'h08, 8'h08, 1'h0, 1'h0, 4'hC, 8'h08);
    mst_issue(1'h0, 32'h0000_0000, 8'h07, 8'h08, 1'h1, 1'h0, 4'h6, 8'h01);
    mst_issue(1'h1, 32'h0000_0000, 8'h10, 8'h08, 1'h0, 1'h1, 4'hF, 8'h08);
    mst_issue(1'h1, 32'h0000_0000, 8'h10, 8'h08, 1'h0, 1'h0, 4'h7, 8'h01);
    mst_issue(1'h0, 32'h0000_0001, 8'h10, 8'h08, 1'h1, 1'h0, 4'hE, 8'h08);
    mst_issue(1'h0, 32'h0000_0000, 8'h10, 8'h00, 1'h1, 1'h0, 4'h6, 8'h01);
  endtask

  task automatic test_fill_drain();
    logic [7:0] b;
    @(posedge clk);
    scsiWide <= 1'h1;
    for (int k = 0; k < 64; k++) begin
      b = 8'(4 * k);
      u_pci_host_model.send({b + 8'h03, b + 8'h02, b + 8'h01, b}, 1'h0, 0);
    end
    repeat (3) @(posedge clk);
    check("ready when full", 32'h0000_0000, {31'h0, pciReady});
    check("activity when full", 32'h0000_0001, {31'h0, activityQ});
    for (int i = 0; i < 128; i++) begin
      scsi_take({8'(2 * i + 1), 8'(2 * i)}, 1'h1);
    end
    repeat (3) @(posedge clk);
    check("ready when drained", 32'h0000_0001, {31'h0, pciReady});
    check("activity when idle", 32'h0000_0000, {31'h0, activityQ});
    check("data parity errors", 32'h0000_0000, perrCnt);
  endtask

  task automatic test_narrow_perr();
    @(posedge clk);
    scsiWide <= 1'h0;
    u_pci_host_model.send(32'h4433_2211, 1'h0, 3);
    u_pci_host_model.send(32'h8877_6655, 1'h0, 3);
    for (int i = 0; i < 8; i++) begin
      scsi_take({8'h00, 8'(8'h11 * (i + 1))}, 1'h0);
    end
    u_pci_host_model.send(32'h0000_0001, 1'h1, 0);
    repeat (3) @(posedge clk);
    check("bad beat flagged", 32'h0000_0001, perrCnt);
    do_reset();
  endtask

  task automatic test_offset();
    for (int i = 0; i < 16; i++) begin
      if (i == 15) check("no overflow at 15", 32'h0000_0000, {31'h0, offsetErrQ});
      @(posedge clk);
      scsiReq <= 1'h1;
      @(posedge clk);
      scsiReq <= 1'h0;
    end
    repeat (3) @(posedge clk);
    check("overflow at 16", 32'h0000_0001, {31'h0, offsetErrQ});
    check("no ack when empty", 32'h0000_0000, ackQ.size());
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    do_reset();
    test_target();
    test_master();
    test_fill_drain();
    test_narrow_perr();
    scsiWide <= 1'h1;
    arb_run(4'hA, 16'h0004, 1'h0);
    arb_run(4'h2, 16'h8000, 1'h1);
    arb_run(4'hF, 16'h1000, 1'h1);
    arb_run(4'h5, 16'h0040, 1'h0);
    test_offset();
    print_verdict();
  end

  initial begin
    #40000;
    $display("watchdog expired");
    error_cnt++;
    print_verdict();
  end
endmodule
